// [verilog/sio_ctrl.v]
// Purpose: mode, clock and pin-function control of a clocked serial channel
// Assumes: AXI4-Lite register access, one system clock, pins synchronised
// Notes: pin outputs are registered, so they follow settings one cycle late
//
// Notes on behaviour
// - two-wire mode uses clock plus a shared data pin, three-wire adds a dedicated output.
// - clock select 00 is external slave clock, 01/10/11 internal 12.5/18.75/37.5 kHz.
// - out_pin_enable at 1 makes the dedicated pin the serial output, else a port line.
// - data_dir_select at 0 leaves the shared pin a port line set by its port flag, at 1 an output.
// - external clock with port flag 0 makes the clock pin a shift clock input when running.
// - internal clock with port flag 1 drives the clock pin, idle high during wait.
// - receive direction with port flag 0 uses the shared pin as serial input when running.
// - transmit direction holds the shared pin idle in wait and drives data when running.
// - msb goes out on the falling clock edge, data enters the lsb on the rising edge.
// - the eighth rising clock edge returns to wait and raises an interrupt.
// - writing 0 to transfer_go while running forces wait and clears the clock counter.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sio_consts.vh"
module sio_ctrl
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // soft resets from the core
    input wire watchdog_stack_reset,
    input wire clock_stop,
    // write address channel
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    input wire awvalid,
    output reg awready,
    // write data channel
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    // write response channel
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // read address channel
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    input wire arvalid,
    output reg arready,
    // read data channel
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // shift clock pin
    input wire port_b_line0_in,
    output reg port_b_line0_out,
    output reg port_b_line0_oe,
    // shared data pin
    input wire port_b_line1_in,
    output reg port_b_line1_out,
    output reg port_b_line1_oe,
    // dedicated data output pin
    input wire port_b_line2_in,
    output reg port_b_line2_out,
    output reg port_b_line2_oe,
    // interrupt
    output reg irq
);

// ------
// link states
// ------
localparam ST_WAIT = 2'b01;
localparam ST_XFER = 2'b10;

// ------
// declarations
// ------
reg [1:0] shift_clk_sel;
reg out_pin_enable;
reg data_dir_select;
reg [2:0] port_flag;
reg [2:0] port_data;
reg irq_en;
reg irq_stat;
reg [1:0] state;
reg [3:0] bit_cnt;
reg [7:0] shift_reg;
reg sck_int;
reg sck_prev;
reg dout;
reg done;
reg aw_held;
reg aw_ok;
reg [5:0] aw_idx;
reg w_held;
reg [31:0] w_data;
reg w_byte0;
reg [31:0] rd_word;
reg rd_ok;
wire [2:0] pin_s;
wire div_tick;
wire master;
wire xfer;
wire eff_clk;
wire sck_fall;
wire sck_rise;
wire wr_fire;
wire wr_en;
wire soft_rst;
wire [5:0] ar_idx;

// ------
// functions
// ------
// word index from a byte address, low bits must be zero
function [6:0] addr_index;
    input [7:0] a;
    begin
        addr_index = {a[1:0] == 2'h0, a[7:2]};
    end
endfunction

// half shift-clock period in system cycles for each internal rate
function [11:0] half_count;
    input [1:0] sel;
    reg [63:0] rate;
    reg [63:0] t;
    begin
        case (sel)
            2'h1: rate = `RATE_SLOW_CHZ;
            2'h2: rate = `RATE_MID_CHZ;
            default: rate = `RATE_FAST_CHZ;
        endcase
        t = (`SYS_CLK_HZ * 64'd100) / (64'd2 * rate);
        half_count = t[11:0];
    end
endfunction

// ------
// pin synchroniser and rate divider
// ------
sio_sync2 #(.WIDTH(3)) u_sync
(
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({port_b_line2_in, port_b_line1_in, port_b_line0_in}),
    .sync_out(pin_s)
);

// divider only runs while the internal clock is actually on the pin
sio_rate_div u_div
(
    .aclk(aclk),
    .aresetn(aresetn),
    .run(xfer && master && port_flag[0]),
    .limit(half_count(shift_clk_sel)),
    .tick(div_tick)
);

// ------
// shift clock source and edge detection
// ------
assign master = shift_clk_sel != `SEL_EXT;
assign xfer = state == ST_XFER;
// counter follows sck_int for an internal clock and the synchronised pin level for an external one with port flag 0, else a constant high
assign eff_clk = master ? sck_int : (port_flag[0] ? 1'b1 : pin_s[0]);
assign sck_fall = sck_prev && !eff_clk;
assign sck_rise = !sck_prev && eff_clk;
assign soft_rst = watchdog_stack_reset || clock_stop;

// ------
// register bus: write side
// ------
assign wr_fire = aw_held && w_held && !bvalid;
assign wr_en = wr_fire && aw_ok && w_byte0;
assign ar_idx = araddr[7:2];

// address and data are taken independently, either order
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_held <= 1'b0;
        aw_ok <= 1'b0;
        aw_idx <= 6'h00;
        w_held <= 1'b0;
        w_data <= 32'h00000000;
        w_byte0 <= 1'b0;
        awready <= 1'b0;
        wready <= 1'b0;
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
    end
    else
    begin
        awready <= !aw_held && !(awvalid && awready);
        wready <= !w_held && !(wvalid && wready);
        if (awvalid && awready)
        begin
            aw_held <= 1'b1;
            aw_idx <= awaddr[7:2];
            aw_ok <= addr_index(awaddr) >= {1'b1, `IDX_CLK_SEL}
                && addr_index(awaddr) <= {1'b1, `IDX_IRQ_CLR}
                && addr_index(awaddr) != {1'b1, `IDX_PIN}
                && addr_index(awaddr) != {1'b1, `IDX_IRQ_STAT};
        end
        if (wvalid && wready)
        begin
            w_held <= 1'b1;
            w_data <= wdata;
            w_byte0 <= wstrb[0];
        end
        if (wr_fire)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b1;
            bresp <= aw_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (bvalid && bready)
        begin
            bvalid <= 1'b0;
        end
    end
end

// ------
// configuration registers
// ------
// only the defined bits are stored, so upper bits never take writes
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        shift_clk_sel <= `CLK_SEL_RST;
        out_pin_enable <= `HIZ_RST;
        data_dir_select <= `DIR_RST;
        port_flag <= `PORT_RST;
        port_data <= `PORT_RST;
        irq_en <= 1'b0;
    end
    else if (soft_rst)
    begin
        shift_clk_sel <= `CLK_SEL_RST;
        out_pin_enable <= 1'b0;
    end
    else if (wr_en)
    begin
        case (aw_idx)
            `IDX_CLK_SEL: shift_clk_sel <= w_data[1:0];
            `IDX_MODE:
            begin
                out_pin_enable <= w_data[`MODE_HIZ];
                data_dir_select <= w_data[`MODE_DIR];
            end
            `IDX_PORT:
            begin
                port_flag <= w_data[2:0];
                port_data <= w_data[6:4];
            end
            `IDX_IRQ_EN: irq_en <= w_data[0];
            default: irq_en <= irq_en;
        endcase
    end
end

// ------
// link sequencing: wait control, clock counter, shift register
// ------
always @(posedge aclk)
begin
    if (!aresetn || soft_rst)
    begin
        state <= ST_WAIT;
        bit_cnt <= 4'h0;
        sck_int <= 1'b1;
        sck_prev <= 1'b1;
        done <= 1'b0;
        if (!aresetn)
        begin
            shift_reg <= `SHIFT_RST;
            dout <= 1'b1;
        end
    end
    else
    begin
        done <= 1'b0;
        sck_prev <= eff_clk;
        case (state)
            ST_WAIT:
            begin
                sck_int <= 1'b1;
                bit_cnt <= 4'h0;
                if (wr_en && aw_idx == `IDX_SHIFT)
                begin
                    shift_reg <= w_data[7:0];
                end
                if (wr_en && aw_idx == `IDX_MODE && w_data[`MODE_GO])
                begin
                    state <= ST_XFER;
                end
            end
            ST_XFER:
            begin
                if (div_tick)
                begin
                    sck_int <= !sck_int;
                end
                if (sck_fall)
                begin
                    bit_cnt <= bit_cnt + 4'h1;
                    dout <= shift_reg[7];
                end
                if (sck_rise && bit_cnt != 4'h0)
                begin
                    shift_reg <= {shift_reg[6:0], pin_s[1]};
                    if (bit_cnt == `BITS_PER_XFER)
                    begin
                        state <= ST_WAIT;
                        bit_cnt <= 4'h0;
                        done <= 1'b1;
                    end
                end
                // writing 1 again while running changes nothing
                if (wr_en && aw_idx == `IDX_MODE && !w_data[`MODE_GO])
                begin
                    state <= ST_WAIT;
                    bit_cnt <= 4'h0;
                    sck_int <= 1'b1;
                end
            end
            default:
            begin
                state <= ST_WAIT;
                bit_cnt <= 4'h0;
            end
        endcase
    end
end

// ------
// interrupt status, enable and output
// ------
// a completion in the clearing cycle stays set
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        irq_stat <= 1'b0;
        irq <= 1'b0;
    end
    else
    begin
        if (done)
        begin
            irq_stat <= 1'b1;
        end
        else if (wr_en && aw_idx == `IDX_IRQ_CLR && w_data[0])
        begin
            irq_stat <= 1'b0;
        end
        irq <= irq_stat && irq_en;
    end
end

// ------
// pin function selection
// ------
// every pin also depends on its port flag, software sets both
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        port_b_line0_out <= 1'b1;
        port_b_line0_oe <= 1'b0;
        port_b_line1_out <= 1'b1;
        port_b_line1_oe <= 1'b0;
        port_b_line2_out <= 1'b1;
        port_b_line2_oe <= 1'b0;
    end
    else
    begin
        // flag 0: input or external clock; flag 1: port out or own clock
        port_b_line0_oe <= port_flag[0];
        port_b_line0_out <= master ? (xfer ? sck_int : 1'b1) : port_data[0];
        // two-wire shared pin: direction bit picks in or out
        port_b_line1_oe <= data_dir_select || port_flag[1];
        if (data_dir_select)
        begin
            port_b_line1_out <= xfer ? dout : 1'b1;
        end
        else
        begin
            port_b_line1_out <= port_data[1];
        end
        // three-wire dedicated output or plain port line
        port_b_line2_oe <= out_pin_enable || port_flag[2];
        port_b_line2_out <= out_pin_enable ? dout : port_data[2];
    end
end

// ------
// register bus: read side
// ------
always @*
begin
    rd_word = 32'h00000000;
    rd_ok = araddr[1:0] == 2'h0;
    case (ar_idx)
        `IDX_CLK_SEL: rd_word[1:0] = shift_clk_sel;
        `IDX_MODE: rd_word[3:0] = {data_dir_select, 1'b0, out_pin_enable, xfer};
        `IDX_SHIFT: rd_word[7:0] = shift_reg;
        `IDX_PORT: rd_word[6:0] = {port_data, 1'b0, port_flag};
        `IDX_PIN: rd_word[2:0] = pin_s;
        `IDX_IRQ_STAT: rd_word[0] = irq_stat;
        `IDX_IRQ_EN: rd_word[0] = irq_en;
        `IDX_IRQ_CLR: rd_word = 32'h00000000;
        default: rd_ok = 1'b0;
    endcase
end

// one read at a time, answered the cycle after the address is taken
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        arready <= 1'b0;
        rvalid <= 1'b0;
        rdata <= 32'h00000000;
        rresp <= `RESP_OKAY;
    end
    else
    begin
        arready <= !rvalid && !(arvalid && arready);
        if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= rd_ok ? rd_word : 32'h00000000;
            rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
        end
    end
end

endmodule

// [verilog/sio_consts.vh]
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 100 MHz system clock, 32-bit register bus
// Notes: register indexes are word indexes, byte address is index times four
`ifndef SIO_CONSTS_VH
`define SIO_CONSTS_VH

// ------
// register indexes
// ------
`define IDX_CLK_SEL 6'h1c
`define IDX_MODE 6'h1d
`define IDX_SHIFT 6'h1e
`define IDX_PORT 6'h1f
`define IDX_PIN 6'h20
`define IDX_IRQ_STAT 6'h21
`define IDX_IRQ_EN 6'h22
`define IDX_IRQ_CLR 6'h23

// ------
// field positions and reset values
// ------
`define MODE_GO 0
`define MODE_HIZ 1
`define MODE_DIR 3
`define CLK_SEL_RST 2'h0
`define MODE_RST 4'h0
`define HIZ_RST 1'b0
`define DIR_RST 1'b0
`define PORT_RST 3'h0
`define SHIFT_RST 8'h00
`define SEL_EXT 2'h0

// ------
// timing: rates in centi-hertz, half periods in system cycles
// ------
`define SYS_CLK_HZ 64'd100000000
`define RATE_SLOW_CHZ 64'd1250000
`define RATE_MID_CHZ 64'd1875000
`define RATE_FAST_CHZ 64'd3750000
`define BITS_PER_XFER 4'h8

// ------
// bus responses
// ------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [verilog/sio_sync2.v]
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module sio_sync2
#(
    parameter WIDTH = 3
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1;

// ----------------------------------------------------------------
// two stages, reset high like idle pins
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        stage1 <= {WIDTH{1'b1}};
        sync_out <= {WIDTH{1'b1}};
    end
    else
    begin
        stage1 <= async_in;
        sync_out <= stage1;
    end
end

endmodule

// [verilog/sio_rate_div.v]
// Purpose: half-period tick generator for the internal shift clock
// Assumes: limit is at least one
// Notes: count restarts whenever run drops
`timescale 1ns/1ps
module sio_rate_div
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire run,
    input wire [11:0] limit,
    // one-cycle enable
    output reg tick
);

reg [11:0] count;

// ----------------------------------------------------------------
// divider
// ----------------------------------------------------------------
always @(posedge aclk)
begin
    if (!aresetn || !run)
    begin
        count <= 12'h000;
        tick <= 1'b0;
    end
    else if (count >= limit - 12'h001)
    begin
        count <= 12'h000;
        tick <= 1'b1;
    end
    else
    begin
        count <= count + 12'h001;
        tick <= 1'b0;
    end
end

endmodule

// [bench/sio_ctrl_chk.sv]
// Purpose: port-level checker for the serial mode and pin control block
// Assumes: one clock domain, synchronous active-low reset
// Notes: pin timing limits follow the slowest internal shift rate
`timescale 1ns/1ps
module sio_ctrl_chk
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus handshakes
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire bready,
    input wire arvalid,
    input wire arready,
    input wire [31:0] rdata,
    input wire rvalid,
    input wire rready,
    // clock pin and interrupt
    input wire port_b_line0_out,
    input wire port_b_line0_oe,
    input wire irq
);
    reg [12:0] low_cnt;

    // ------------------------------------------------------------
    // helper: length of the driven-low stretch of the clock pin
    // ------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn || !port_b_line0_oe || port_b_line0_out)
            low_cnt <= 13'h0000;
        else
            low_cnt <= low_cnt + 13'h0001;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_b_wait;
        bvalid && !bready;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_take |-> ##[1:2] bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_b_wait |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (rvalid |-> !arready)
        else $error("read taken while answer held");
    AST_READY_UP: assert property ($rose(aresetn) |=> awready && wready && arready)
        else $error("bus not ready after reset");
    AST_SCK_LOW_MAX: assert property (low_cnt <= 13'h0fa0)
        else $error("clock pin low too long");
    AST_SCK_IDLE: assert property ($rose(port_b_line0_oe) |-> port_b_line0_out)
        else $error("clock pin driven low at start");
    AST_IRQ_DROP: assert property ($fell(irq) |-> $past(bvalid, 1) || $past(bvalid, 2)
        || $past(bvalid, 3) || $past(bvalid, 4))
        else $error("interrupt dropped without a write");
endmodule

bind sio_ctrl sio_ctrl_chk sio_ctrl_chk_inst (.*);

// [bench/sio_peer.sv]
// Purpose: behavioural serial peer on the clock and data lines
// Assumes: lines resolved by the bench from all drivers
// Notes: makes the clock only inside frames, 80 ns period
`timescale 1ns/1ps
module sio_peer
(
    // resolved lines
    input wire sck_line,
    input wire din,
    // peer drives
    output reg sck,
    output reg sdo
);
    reg [7:0] tx;
    reg [7:0] rx;

    // ------------------------------------------------------------
    // frame clock, off the system clock phase
    // ------------------------------------------------------------
    initial
    begin
        sck = 1'b1;
        sdo = 1'b1;
        tx = 8'h00;
        rx = 8'h00;
    end
    task frame(input integer n);
        integer i;
        begin
            #3;
            for (i = 0; i < n; i = i + 1)
            begin
                #40 sck = 1'b0;
                #40 sck = 1'b1;
            end
            // stale data must not look valid after the frame
            #40 sdo = ~sdo;
        end
    endtask
    // msb out on falling, lsb in on rising
    always @(negedge sck_line)
    begin
        sdo = tx[7];
        tx = {tx[6:0], 1'b0};
    end
    always @(posedge sck_line) rx = {rx[6:0], din};
endmodule

// [bench/serial_io_mode_and_pin_control_test.sv]
// Purpose: self-checking bench for the serial mode and pin control block
// Assumes: bus tasks start one edge after the previous one ended
// Notes: full transfer at the fastest rate only, to keep the run short
`timescale 1ns/1ps
`include "sio_consts.vh"
module serial_io_mode_and_pin_control_test;
    localparam [7:0] A_SEL = {`IDX_CLK_SEL, 2'b00};
    localparam [7:0] A_MODE = {`IDX_MODE, 2'b00};
    localparam [7:0] A_SHIFT = {`IDX_SHIFT, 2'b00};
    localparam [7:0] A_PORT = {`IDX_PORT, 2'b00};
    localparam [7:0] A_PIN = {`IDX_PIN, 2'b00};
    localparam [7:0] A_STAT = {`IDX_IRQ_STAT, 2'b00};
    localparam [7:0] A_IEN = {`IDX_IRQ_EN, 2'b00};
    localparam [7:0] A_CLR = {`IDX_IRQ_CLR, 2'b00};
    reg aclk, aresetn, watchdog_stack_reset, clock_stop, two_wire;
    reg awvalid, wvalid, bready, arvalid, rready;
    reg [7:0] awaddr, araddr;
    reg [31:0] wdata, rv;
    reg [1:0] rr;
    reg [3:0] wstrb;
    reg [2:0] awprot, arprot;
    reg [63:0] hp;
    wire awready, wready, bvalid, arready, rvalid, irq, peer_sck, peer_sdo;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire port_b_line0_out, port_b_line0_oe, port_b_line1_out, port_b_line1_oe;
    wire port_b_line2_out, port_b_line2_oe;
    integer err_total, checks, cyc, i, n;
    // line levels from all drivers; dedicated output has a pull-up
    wire sck_line = port_b_line0_oe ? port_b_line0_out : peer_sck;
    wire dat_line = port_b_line1_oe ? port_b_line1_out : peer_sdo;
    wire so_line = port_b_line2_oe ? port_b_line2_out : 1'b1;
    wire peer_din = two_wire ? dat_line : so_line;

    // ------
    // design, peer, clock and timeout
    // ------
    sio_ctrl sio_ctrl_inst (.aclk, .aresetn, .watchdog_stack_reset, .clock_stop, .awaddr,
        .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .port_b_line0_in(sck_line), .port_b_line0_out, .port_b_line0_oe,
        .port_b_line1_in(dat_line), .port_b_line1_out, .port_b_line1_oe,
        .port_b_line2_in(so_line), .port_b_line2_out, .port_b_line2_oe, .irq);
    sio_peer sio_peer_inst (.sck_line(sck_line), .din(peer_din), .sck(peer_sck),
        .sdo(peer_sdo));
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // a hang is cut short well above the expected run length
    always @(posedge aclk)
    begin
        cyc = cyc + 1;
        if (cyc == 80000)
        begin
            err_total = err_total + 1;
            results;
        end
    end

    // ------
    // bus cycles, compare and verdict
    // ------
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) rr = bresp;
            end
            while (bvalid !== 1'b1);
            bready <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (arvalid && arready) arvalid <= 1'b0;
            end
            while (rvalid !== 1'b1);
            rv = rdata;
            rr = rresp;
            rready <= 1'b0;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp)
            begin
                err_total = err_total + 1;
                $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // ------
    // scenarios
    // ------
    // reset values, unused bits, refused accesses, soft resets
    task t_regs;
        begin
            rd(A_SEL); chk(rv, 32'h0);
            rd(A_MODE); chk(rv, 32'h0);
            rd(8'h00); chk({rr, rv}, {`RESP_SLVERR, 32'h0});
            wr(A_PIN, 32'h0); chk(rr, `RESP_SLVERR);
            for (i = 0; i < 2; i = i + 1)
            begin
                wr(A_SEL, 32'hffffffff); rd(A_SEL); chk(rv, 32'h3);
                wr(A_MODE, 32'hfffffffa); rd(A_MODE); chk(rv, 32'ha);
                @(posedge aclk);
                if (i == 0) watchdog_stack_reset <= 1'b1;
                else clock_stop <= 1'b1;
                @(posedge aclk);
                watchdog_stack_reset <= 1'b0;
                clock_stop <= 1'b0;
                rd(A_SEL); chk(rv, 32'h0);
                rd(A_MODE); chk(rv, 32'h8);
            end
            // a write without the low byte lane changes nothing
            wstrb <= 4'h0;
            wr(A_SEL, 32'h3); chk(rr, `RESP_OKAY);
            wstrb <= 4'hf;
            rd(A_SEL); chk(rv, 32'h0);
            wr(A_MODE, 32'h0);
        end
    endtask
    // pin functions chosen by port flags with serial in wait
    task t_pins;
        begin
            wr(A_PORT, 32'h73); repeat (3) @(posedge aclk);
            chk({port_b_line0_oe, port_b_line0_out, port_b_line1_oe, port_b_line1_out}, 4'hf);
            wr(A_PORT, 32'h0); repeat (3) @(posedge aclk);
            chk({port_b_line0_oe, port_b_line1_oe, port_b_line2_oe}, 3'h0);
            wr(A_MODE, 32'h2); repeat (3) @(posedge aclk);
            chk(port_b_line2_oe, 1'b1);
        end
    endtask
    // three-wire slave byte both ways, then interrupt raise, mask, clear
    task t_slave;
        begin
            two_wire = 1'b0;
            wr(A_SHIFT, 32'ha5); wr(A_IEN, 32'h1);
            sio_peer_inst.tx = 8'h3c;
            chk(port_b_line0_oe, 1'b0);
            wr(A_MODE, 32'h3); rd(A_MODE); chk(rv, 32'h3);
            sio_peer_inst.frame(8);
            repeat (8) @(posedge aclk);
            rd(A_MODE); chk(rv, 32'h2);
            rd(A_SHIFT); chk(rv, 32'h3c);
            chk(sio_peer_inst.rx, 8'ha5);
            rd(A_STAT); chk(rv, 32'h1);
            chk(irq, 1'b1);
            wr(A_IEN, 32'h0); repeat (3) @(posedge aclk); chk(irq, 1'b0);
            wr(A_IEN, 32'h1); repeat (3) @(posedge aclk); chk(irq, 1'b1);
            wr(A_CLR, 32'h1); repeat (3) @(posedge aclk); chk(irq, 1'b0);
            rd(A_STAT); chk(rv, 32'h0);
        end
    endtask
    // forced wait mid-byte, then restart counts eight clocks afresh
    task t_force;
        begin
            wr(A_MODE, 32'h3); sio_peer_inst.frame(3);
            wr(A_MODE, 32'h2); rd(A_MODE); chk(rv, 32'h2);
            wr(A_MODE, 32'h3); sio_peer_inst.frame(5);
            rd(A_MODE); chk(rv, 32'h3);
            sio_peer_inst.frame(3);
            repeat (8) @(posedge aclk);
            rd(A_MODE); chk(rv, 32'h2);
            wr(A_CLR, 32'h1);
        end
    endtask
    // two-wire master transmit, every internal rate timed on the pin
    task t_master;
        begin
            two_wire = 1'b1;
            wr(A_MODE, 32'h8);
            for (i = 1; i < 4; i = i + 1)
            begin
                wr(A_SEL, i); wr(A_PORT, 32'h1); repeat (3) @(posedge aclk);
                chk({port_b_line0_oe, port_b_line0_out, port_b_line1_oe}, 3'h7);
                wr(A_SHIFT, 32'h96); wr(A_MODE, 32'h9);
                hp = (i == 1) ? `RATE_SLOW_CHZ : (i == 2) ? `RATE_MID_CHZ : `RATE_FAST_CHZ;
                hp = `SYS_CLK_HZ * 64'd100 / (64'd2 * hp);
                for (n = 0; port_b_line0_out === 1'b1 && n < 9000; n = n + 1) @(posedge aclk);
                for (n = 0; port_b_line0_out === 1'b0 && n < 9000; n = n + 1) @(posedge aclk);
                chk(n, hp[31:0]);
                if (i < 3)
                begin
                    wr(A_MODE, 32'h8); repeat (3) @(posedge aclk);
                    chk(port_b_line0_out, 1'b1);
                end
            end
            for (n = 0; irq !== 1'b1 && n < 30000; n = n + 1) @(posedge aclk);
            chk(sio_peer_inst.rx, 8'h96);
            chk(port_b_line0_out, 1'b1);
            rd(A_MODE); chk(rv, 32'h8);
            wr(A_CLR, 32'h1);
        end
    endtask

    // ------
    // main sequence, with a second reset at the end
    // ------
    initial
    begin
        {aresetn, watchdog_stack_reset, clock_stop, two_wire} = 4'h0;
        {awprot, arprot, wstrb} = 10'h00f;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, rv, rr} = 82'h0;
        {err_total, checks, cyc} = 96'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_pins;
        t_slave;
        t_force;
        t_master;
        wr(A_SEL, 32'h3);
        @(posedge aclk) aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_SEL); chk(rv, 32'h0);
        results;
    end
endmodule
